// file: fcs_pkg.sv
// constants shared by the flash command sequencer
package fcs_pkg;
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_DAT = 8'h04;
  localparam logic [7:0] OFS_ADR = 8'h08;
  localparam logic [7:0] OFS_STA = 8'h0c;
  localparam logic [7:0] OFS_SIGN = 8'h10;
  localparam logic [7:0] OFS_PRO = 8'h14;
  localparam logic [7:0] OFS_MOD = 8'h18;
  localparam logic [7:0] OFS_KEY = 8'h1c;
  localparam logic [7:0] OFS_TIM = 8'h20;
  localparam logic [7:0] CMD_NULL = 8'h00;
  localparam logic [7:0] CMD_READ = 8'h01;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_ERWR = 8'h03;
  localparam logic [7:0] CMD_VERIFY = 8'h04;
  localparam logic [7:0] CMD_ERASE = 8'h05;
  localparam logic [7:0] CMD_MASS = 8'h06;
  localparam logic [7:0] CMD_DONE_RD = 8'h07;
  localparam logic [7:0] CMD_SIGN = 8'h0b;
  localparam logic [7:0] CMD_PROT = 8'h0c;
  localparam logic [7:0] CMD_PING = 8'h0f;
  localparam int STA_DONE = 0;
  localparam int STA_MISMATCH = 1;
  localparam int STA_BUSY = 2;
  localparam int STA_BLOCKED = 3;
  localparam int MOD_EW_BIT = 3;
  localparam logic [7:0] MOD_RST = 8'h80;
  // key values are arbitrary
  localparam logic [31:0] MASS_KEY = 32'h0000_5a5a;
  localparam logic [31:0] PROT_KEY = 32'h0000_c3c3;
  localparam int CLK_MHZ = 100;
  localparam int WRITE_US = 50;
  localparam int ERWR_MS = 20;
  localparam int MASS_MS = 2480;
  localparam int WRITE_CYC = WRITE_US * CLK_MHZ;
  localparam int ERWR_CYC = ERWR_MS * 1000 * CLK_MHZ;
  localparam int MASS_CYC = MASS_MS * 1000 * CLK_MHZ;
  localparam int SIG_CYC = 32778;
  localparam int FLASH_ACCESS_NS = 22;
  localparam logic [3:0] COST_FETCH32 = 4'h2;
  localparam logic [3:0] COST_FETCH16 = 4'h1;
  localparam logic [3:0] COST_DATA = 4'h4;
  localparam logic [3:0] COST_BRANCH = 4'h5;
  localparam logic [1:0] KIND_FETCH32 = 2'h0;
  localparam logic [1:0] KIND_FETCH16 = 2'h1;
  localparam logic [1:0] KIND_DATA = 2'h2;
  localparam logic [1:0] KIND_BRANCH = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : fcs_pkg

// file: fcs_top.sv
// flash command sequencer with axi4-lite register slave
// Function
// - code 0x00 idles; code 0x01 loads data register from addressed word
// - code 0x02 programs data register at address, lasting 50 us
// - code 0x03 erases page then programs data, lasting 20 ms
// - verify compares addressed word with data, result in status bit 1
// - code 0x05 erases only the addressed page
// - code 0x06 erases user space, keeps 2 kB kernel, lasting 2.48 s
// - mass erase runs only after a preceding key sequence
// - code 0x0b builds 24-bit signature of the block in 32778 cycles
// - code 0x0c saves protection once; later protect commands do nothing
// - protection cleared only by mass erase or the key
// - code 0x0f does nothing but raises the interrupt
// - command register reads 0x07 once codes 0x00 to 0x06 end; timed codes read back their own code while busy
// - array is 16 bits wide, 22 ns per word, two per 32-bit word
// - fetch costs two cycles for 32-bit, one for 16-bit instructions
// - data access adds decode, two gather cycles and one dead cycle
// - control flow adds one decode cycle and four refill cycles
`timescale 1ns/1ps
module fcs_top #(
  parameter int WORDS = 32768,
  parameter int PAGE_WORDS = 256,
  parameter int KERNEL_WORDS = 1024,
  parameter int WRITE_CYCLES = fcs_pkg::WRITE_CYC,
  parameter int ERWR_CYCLES = fcs_pkg::ERWR_CYC,
  parameter int MASS_CYCLES = fcs_pkg::MASS_CYC,
  parameter int SIG_CYCLES = fcs_pkg::SIG_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic flash_irq
);
  localparam int AW = $clog2(WORDS);

  if ((1 << AW) != WORDS || AW < 5 || PAGE_WORDS > WORDS || KERNEL_WORDS >= WORDS
      || (PAGE_WORDS & (PAGE_WORDS - 1)) != 0 || WRITE_CYCLES < 1 || SIG_CYCLES <= WORDS)
  begin : g_chk
    $error("fcs_top: unsupported parameter values");
  end

  typedef enum logic [1:0] {FCS_IDLE, FCS_RUN} fcs_state_e;
  typedef enum logic [1:0] {FCS_OP_PROG, FCS_OP_ERASE, FCS_OP_MASS, FCS_OP_SIGN} fcs_op_e;

  function automatic logic [31:0] fcs_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction : fcs_merge

  // one protection bit guards each 1/32 of the array
  function automatic logic fcs_prot_hit(input logic [31:0] prot, input logic [AW-1:0] a);
    return prot[a[AW-1 -: 5]];
  endfunction : fcs_prot_hit

  // single 16-bit array; a read command loads one addressed word into the data register
  logic [15:0] mem [WORDS];
  logic mem_we;
  logic [AW-1:0] mem_wa;
  logic [15:0] mem_wd;

  // bus state
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic do_wr;

  // sequencer state
  fcs_state_e st_r, st_nxt;
  fcs_op_e op_r, op_nxt;
  logic [7:0] cmd_r, cmd_nxt, mode_r, mode_nxt;
  logic [15:0] data_r, data_nxt;
  logic [31:0] addr_r, addr_nxt, prot_r, prot_nxt, saved_r, saved_nxt;
  logic used_r, used_nxt, armed_r, armed_nxt, prog_r, prog_nxt, walk_r, walk_nxt;
  logic done_r, done_nxt, mism_r, mism_nxt, blk_r, blk_nxt, irq_r, irq_nxt;
  logic [23:0] sig_r, sig_nxt;
  logic [31:0] timer_r, timer_nxt;
  logic [AW-1:0] ptr_r, ptr_nxt, end_r, end_nxt;
  logic [1:0] kind_r, kind_nxt;
  logic [3:0] cost;
  logic [AW-1:0] wa;
  logic [AW-1:0] page_base;

  assign wa = addr_r[AW-1:0];
  assign page_base = wa & ~AW'(PAGE_WORDS - 1);
  assign do_wr = aw_held_r && w_held_r && !bvalid_r;

  always_comb
  begin
    unique case (kind_r)
      fcs_pkg::KIND_FETCH32: cost = fcs_pkg::COST_FETCH32;
      fcs_pkg::KIND_FETCH16: cost = fcs_pkg::COST_FETCH16;
      fcs_pkg::KIND_DATA: cost = fcs_pkg::COST_DATA;
      fcs_pkg::KIND_BRANCH: cost = fcs_pkg::COST_BRANCH;
    endcase
  end

  always_comb
  begin
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt = w_held_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (s_axi_awvalid && awready_r)
    begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r)
    begin
      w_held_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (do_wr)
    begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = (aw_addr_r > fcs_pkg::OFS_TIM || aw_addr_r[1:0] != 2'h0) ?
                  fcs_pkg::RESP_SLVERR : fcs_pkg::RESP_OKAY;
    end
    if (bvalid_r && s_axi_bready)
    begin
      bvalid_nxt = 1'b0;
    end
    if (rvalid_r && s_axi_rready)
    begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && arready_r)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = fcs_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        fcs_pkg::OFS_CMD: rdata_nxt = {24'h0, cmd_r};
        fcs_pkg::OFS_DAT: rdata_nxt = {16'h0, data_r};
        fcs_pkg::OFS_ADR: rdata_nxt = addr_r;
        fcs_pkg::OFS_STA: rdata_nxt = {28'h0, blk_r, st_r == FCS_RUN, mism_r, done_r};
        fcs_pkg::OFS_SIGN: rdata_nxt = {8'h0, sig_r};
        fcs_pkg::OFS_PRO: rdata_nxt = used_r ? saved_r : prot_r;
        fcs_pkg::OFS_MOD: rdata_nxt = {24'h0, mode_r};
        fcs_pkg::OFS_KEY: rdata_nxt = 32'h0;
        fcs_pkg::OFS_TIM: rdata_nxt = {24'h0, cost, 2'h0, kind_r};
        default:
        begin
          rdata_nxt = 32'h0;
          rresp_nxt = fcs_pkg::RESP_SLVERR;
        end
      endcase
    end
    awready_nxt = !aw_held_nxt;
    wready_nxt = !w_held_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_comb
  begin
    logic [31:0] wv;
    logic [31:0] dm;
    logic [31:0] mm;
    logic [7:0] code;
    wv = fcs_merge(32'h0, w_data_r, w_strb_r);
    dm = fcs_merge({16'h0, data_r}, w_data_r, w_strb_r);
    mm = fcs_merge({24'h0, mode_r}, w_data_r, w_strb_r);
    code = wv[7:0];
    st_nxt = st_r;
    op_nxt = op_r;
    cmd_nxt = cmd_r;
    mode_nxt = mode_r;
    data_nxt = data_r;
    addr_nxt = addr_r;
    prot_nxt = prot_r;
    saved_nxt = saved_r;
    used_nxt = used_r;
    armed_nxt = armed_r;
    prog_nxt = prog_r;
    walk_nxt = walk_r;
    done_nxt = done_r;
    mism_nxt = mism_r;
    blk_nxt = blk_r;
    irq_nxt = 1'b0;
    sig_nxt = sig_r;
    timer_nxt = timer_r;
    ptr_nxt = ptr_r;
    end_nxt = end_r;
    kind_nxt = kind_r;
    mem_we = 1'b0;
    mem_wa = wa;
    mem_wd = data_r;
    if (do_wr)
    begin
      unique case (aw_addr_r)
        fcs_pkg::OFS_DAT: data_nxt = dm[15:0];
        fcs_pkg::OFS_ADR: addr_nxt = fcs_merge(addr_r, w_data_r, w_strb_r);
        fcs_pkg::OFS_PRO: prot_nxt = fcs_merge(prot_r, w_data_r, w_strb_r);
        fcs_pkg::OFS_MOD: mode_nxt = mm[7:0];
        fcs_pkg::OFS_TIM: kind_nxt = wv[1:0];
        fcs_pkg::OFS_KEY:
        begin
          armed_nxt = (wv == fcs_pkg::MASS_KEY);
          if (wv == fcs_pkg::PROT_KEY)
          begin
            saved_nxt = 32'h0;
            used_nxt = 1'b0;
          end
        end
        fcs_pkg::OFS_CMD:
        begin
          // a command written while busy is dropped whole
          if (st_r == FCS_IDLE)
          begin
            armed_nxt = 1'b0;
            done_nxt = 1'b0;
            blk_nxt = 1'b0;
            cmd_nxt = code;
            unique case (code)
              fcs_pkg::CMD_NULL:
              begin
                cmd_nxt = fcs_pkg::CMD_DONE_RD;
                done_nxt = 1'b1;
              end
              fcs_pkg::CMD_READ:
              begin
                data_nxt = mem[wa];
                cmd_nxt = fcs_pkg::CMD_DONE_RD;
                done_nxt = 1'b1;
              end
              fcs_pkg::CMD_VERIFY:
              begin
                mism_nxt = (mem[wa] != data_r);
                cmd_nxt = fcs_pkg::CMD_DONE_RD;
                done_nxt = 1'b1;
              end
              fcs_pkg::CMD_WRITE, fcs_pkg::CMD_ERWR, fcs_pkg::CMD_ERASE:
              begin
                // erase/write enable off or a guarded region blocks the command
                if (!mode_r[fcs_pkg::MOD_EW_BIT] || fcs_prot_hit(saved_r, wa))
                begin
                  blk_nxt = 1'b1;
                  cmd_nxt = fcs_pkg::CMD_DONE_RD;
                end
                else
                begin
                  st_nxt = FCS_RUN;
                  op_nxt = (code == fcs_pkg::CMD_WRITE) ? FCS_OP_PROG : FCS_OP_ERASE;
                  prog_nxt = (code != fcs_pkg::CMD_ERASE);
                  walk_nxt = (code != fcs_pkg::CMD_WRITE);
                  ptr_nxt = page_base;
                  end_nxt = page_base | AW'(PAGE_WORDS - 1);
                  timer_nxt = (code == fcs_pkg::CMD_WRITE) ? 32'(WRITE_CYCLES) : 32'(ERWR_CYCLES);
                end
              end
              fcs_pkg::CMD_MASS:
              begin
                if (!armed_r || !mode_r[fcs_pkg::MOD_EW_BIT])
                begin
                  blk_nxt = 1'b1;
                  cmd_nxt = fcs_pkg::CMD_DONE_RD;
                end
                else
                begin
                  st_nxt = FCS_RUN;
                  op_nxt = FCS_OP_MASS;
                  prog_nxt = 1'b0;
                  walk_nxt = 1'b1;
                  ptr_nxt = '0;
                  end_nxt = AW'(WORDS - KERNEL_WORDS - 1);
                  timer_nxt = 32'(MASS_CYCLES);
                end
              end
              fcs_pkg::CMD_SIGN:
              begin
                st_nxt = FCS_RUN;
                op_nxt = FCS_OP_SIGN;
                prog_nxt = 1'b0;
                walk_nxt = 1'b1;
                ptr_nxt = '0;
                end_nxt = AW'(WORDS - 1);
                sig_nxt = 24'h0;
                timer_nxt = 32'(SIG_CYCLES);
              end
              fcs_pkg::CMD_PROT:
              begin
                if (!used_r)
                begin
                  saved_nxt = prot_r;
                  used_nxt = 1'b1;
                end
                done_nxt = 1'b1;
              end
              fcs_pkg::CMD_PING:
              begin
                irq_nxt = 1'b1;
                done_nxt = 1'b1;
              end
              default: ;
            endcase
          end
        end
        default: ;
      endcase
    end
    if (st_r == FCS_RUN)
    begin
      timer_nxt = (timer_r > 32'h1) ? timer_r - 32'h1 : 32'h1;
      if (walk_r)
      begin
        if (op_r == FCS_OP_SIGN)
        begin
          sig_nxt = {sig_r[22:0], sig_r[23]} ^ {8'h0, mem[ptr_r]};
        end
        else
        begin
          mem_we = 1'b1;
          mem_wa = ptr_r;
          mem_wd = 16'hffff;
        end
        ptr_nxt = ptr_r + AW'(1);
        walk_nxt = (ptr_r != end_r);
      end
      // short timer settings still wait for the walk to end
      else if (timer_r == 32'h1)
      begin
        st_nxt = FCS_IDLE;
        done_nxt = 1'b1;
        if (prog_r)
        begin
          mem_we = 1'b1;
        end
        if (op_r == FCS_OP_MASS)
        begin
          saved_nxt = 32'h0;
          used_nxt = 1'b0;
        end
        if (op_r != FCS_OP_SIGN)
        begin
          cmd_nxt = fcs_pkg::CMD_DONE_RD;
        end
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (mem_we)
    begin
      mem[mem_wa] <= mem_wd;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h0;
      w_held_r <= 1'b0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= 2'h0;
      rdata_r <= 32'h0;
    end
    else
    begin
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r <= w_held_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      st_r <= FCS_IDLE;
      op_r <= FCS_OP_PROG;
      cmd_r <= fcs_pkg::CMD_NULL;
      mode_r <= fcs_pkg::MOD_RST;
      data_r <= 16'h0;
      addr_r <= 32'h0;
      prot_r <= 32'h0;
      saved_r <= 32'h0;
      used_r <= 1'b0;
      armed_r <= 1'b0;
      prog_r <= 1'b0;
      walk_r <= 1'b0;
      done_r <= 1'b0;
      mism_r <= 1'b0;
      blk_r <= 1'b0;
      irq_r <= 1'b0;
      sig_r <= 24'h0;
      timer_r <= 32'h0;
      ptr_r <= '0;
      end_r <= '0;
      kind_r <= 2'h0;
    end
    else
    begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      cmd_r <= cmd_nxt;
      mode_r <= mode_nxt;
      data_r <= data_nxt;
      addr_r <= addr_nxt;
      prot_r <= prot_nxt;
      saved_r <= saved_nxt;
      used_r <= used_nxt;
      armed_r <= armed_nxt;
      prog_r <= prog_nxt;
      walk_r <= walk_nxt;
      done_r <= done_nxt;
      mism_r <= mism_nxt;
      blk_r <= blk_nxt;
      irq_r <= irq_nxt;
      sig_r <= sig_nxt;
      timer_r <= timer_nxt;
      ptr_r <= ptr_nxt;
      end_r <= end_nxt;
      kind_r <= kind_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign flash_irq = irq_r;
endmodule : fcs_top

// file: fcs_top_asserts.sv
// assertions on the sequencer's register bus and interrupt ports
`timescale 1ns/1ps
module fcs_top_chk (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic flash_irq
);
  logic [7:0] aw_r;
  logic [7:0] ar_r;
  logic [7:0] w_r;
  // last accepted write and read addresses and low write data byte, so responses can be tied to their cause
  always_ff @(posedge core_clk)
  begin
    if (s_axi_awvalid && s_axi_awready) aw_r <= s_axi_awaddr;
    if (s_axi_arvalid && s_axi_arready) ar_r <= s_axi_araddr;
    if (s_axi_wvalid && s_axi_wready) w_r <= s_axi_wdata[7:0];
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response changed before accept");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before accept");
  AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid) else $error("write response late");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  AST_RD_UNMAPPED: assert property (s_axi_rvalid && (ar_r > fcs_pkg::OFS_TIM || ar_r[1:0] != 2'h0)
    |-> s_axi_rresp == fcs_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  AST_WR_UNMAPPED: assert property (s_axi_bvalid && (aw_r > fcs_pkg::OFS_TIM || aw_r[1:0] != 2'h0)
    |-> s_axi_bresp == fcs_pkg::RESP_SLVERR) else $error("unmapped write not refused");
  AST_IRQ_PULSE: assert property (flash_irq |=> !flash_irq)
    else $error("interrupt wider than one cycle");
  AST_IRQ_SRC: assert property (flash_irq |-> aw_r == fcs_pkg::OFS_CMD && w_r == fcs_pkg::CMD_PING)
    else $error("interrupt without ping command");
  AST_RST_QUIET: assert property ($past(sys_rst) |-> !s_axi_bvalid && !s_axi_rvalid && !flash_irq)
    else $error("outputs active right after reset");
  cover property (s_axi_bvalid && !s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rresp == fcs_pkg::RESP_SLVERR);
  cover property (flash_irq);
endmodule : fcs_top_chk

bind fcs_top fcs_top_chk u_chk (.*);

// file: fcs_cpu_model.sv
// processor-side register bus master with slow and prompt response acceptance
`timescale 1ns/1ps
module fcs_cpu_model (
  input wire logic core_clk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial
  begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end
  // dly holds off the response accept, so the slave must keep its answer standing
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input int dly, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b0;
    while (!(aw_ok && w_ok))
    begin
      @(posedge core_clk);
      if (!aw_ok && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (!w_ok && s_axi_wready) s_axi_wvalid <= 1'b0;
      aw_ok = aw_ok || s_axi_awready;
      w_ok = w_ok || s_axi_wready;
    end
    repeat (dly) @(posedge core_clk);
    s_axi_bready <= 1'b1;
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a, input int dly, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b0;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    repeat (dly) @(posedge core_clk);
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
  endtask : rd
endmodule : fcs_cpu_model

// file: tb_fcs_top.sv
// self-checking testbench for the flash command sequencer
`timescale 1ns/1ps
module tb_fcs_top;
  localparam int NW = 64;
  localparam int NQ = 20;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, flash_irq;
  int failures = 0;
  int comparisons = 0;
  int seed = 31150;
  int irqs = 0;
  logic [31:0] rdv;
  logic [15:0] m [NW];
  logic [65:0] rq [$];
  logic [1:0] bq [$];
  logic [7:0] rsv [6] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0d, 8'h0e};
  logic [3:0] cost [4] = '{fcs_pkg::COST_FETCH32, fcs_pkg::COST_FETCH16, fcs_pkg::COST_DATA, fcs_pkg::COST_BRANCH};
  // long timed operations shortened so the whole run stays brief
  fcs_top #(.WORDS(NW), .PAGE_WORDS(8), .KERNEL_WORDS(16), .WRITE_CYCLES(60), .ERWR_CYCLES(NQ),
    .MASS_CYCLES(NQ), .SIG_CYCLES(100)) u_dut (.*);
  fcs_cpu_model u_cpu (.*);
  always #5 core_clk = ~core_clk;
  task automatic finish_test;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp
  always @(posedge core_clk)
  begin
    if (flash_irq === 1'b1) irqs++;
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
    begin
      cmp(s_axi_rdata & rq[0][63:32], rq[0][31:0], "read data");
      cmp({30'h0, s_axi_rresp}, {30'h0, rq[0][65:64]}, "read response");
      void'(rq.pop_front());
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      cmp({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()}, "write response");
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = fcs_pkg::RESP_OKAY);
    logic [1:0] r;
    bq.push_back(er);
    u_cpu.wr(a, d, $random(seed) & 3, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] mk = 32'hffff_ffff,
    input logic [1:0] er = fcs_pkg::RESP_OKAY);
    rq.push_back({er, mk, ex & mk});
    u_cpu.rd(a, $random(seed) & 3, rdv);
  endtask : rd
  task automatic idle;
    int n;
    n = 0;
    @(posedge core_clk);
    do
    begin
      rd(fcs_pkg::OFS_STA, 32'h0, 32'h0);
      n++;
    end
    while (rdv[fcs_pkg::STA_BUSY] === 1'b1 && n < 100);
    if (rdv[fcs_pkg::STA_BUSY] !== 1'b0)
    begin
      failures++;
      $display("[ERR] %0t sequencer stays busy", $time);
    end
  endtask : idle
  task automatic run(input logic [7:0] c);
    wr(fcs_pkg::OFS_CMD, {24'h0, c});
    idle();
  endtask : run
  task automatic wf(input int i, input logic [15:0] d);
    wr(fcs_pkg::OFS_ADR, i);
    wr(fcs_pkg::OFS_DAT, {16'h0, d});
    run(fcs_pkg::CMD_WRITE);
    m[i] = d;
  endtask : wf
  task automatic ck(input int i);
    wr(fcs_pkg::OFS_ADR, i);
    run(fcs_pkg::CMD_READ);
    rd(fcs_pkg::OFS_DAT, {16'h0, m[i]});
  endtask : ck
  function automatic logic [31:0] sig_of();
    logic [23:0] s;
    s = 24'h0;
    for (int i = 0; i < NW; i++) s = {s[22:0], s[23]} ^ {8'h0, m[i]};
    return {8'h0, s};
  endfunction : sig_of
  initial
  begin
    #(60000 * 10);
    failures++;
    finish_test();
  end
  initial
  begin
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    rd(fcs_pkg::OFS_MOD, 32'h80);
    rd(fcs_pkg::OFS_CMD, 32'h0);
    rd(8'h24, 32'h0, 32'hffff_ffff, fcs_pkg::RESP_SLVERR);
    rd(8'h05, 32'h0, 32'hffff_ffff, fcs_pkg::RESP_SLVERR);
    wr(8'h24, 32'h1, fcs_pkg::RESP_SLVERR);
    wr(fcs_pkg::OFS_ADR, 32'h2);
    run(fcs_pkg::CMD_WRITE);
    rd(fcs_pkg::OFS_STA, 32'h8, 32'h8);
    wr(fcs_pkg::OFS_MOD, 32'h88);
    wr(fcs_pkg::OFS_ADR, 32'h0);
    m[0] = 16'h5a3c;
    wr(fcs_pkg::OFS_DAT, {16'h0, m[0]});
    wr(fcs_pkg::OFS_CMD, {24'h0, fcs_pkg::CMD_WRITE});
    rd(fcs_pkg::OFS_STA, 32'h4, 32'h4);
    wr(fcs_pkg::OFS_CMD, {24'h0, fcs_pkg::CMD_ERASE});
    rd(fcs_pkg::OFS_CMD, {24'h0, fcs_pkg::CMD_WRITE});
    idle();
    rd(fcs_pkg::OFS_CMD, 32'h7);
    for (int i = 1; i < NW; i++) wf(i, 16'($random(seed)));
    for (int i = 0; i < NW; i++) ck(i);
    rd(fcs_pkg::OFS_CMD, 32'h7);
    run(fcs_pkg::CMD_NULL);
    rd(fcs_pkg::OFS_CMD, 32'h7);
    run(fcs_pkg::CMD_SIGN);
    rd(fcs_pkg::OFS_SIGN, sig_of());
    rd(fcs_pkg::OFS_CMD, {24'h0, fcs_pkg::CMD_SIGN});
    wr(fcs_pkg::OFS_ADR, 32'h3);
    wr(fcs_pkg::OFS_DAT, {16'h0, m[3] ^ 16'h1});
    run(fcs_pkg::CMD_VERIFY);
    rd(fcs_pkg::OFS_STA, 32'h2, 32'h2);
    wr(fcs_pkg::OFS_DAT, {16'h0, m[3]});
    run(fcs_pkg::CMD_VERIFY);
    rd(fcs_pkg::OFS_STA, 32'h0, 32'h2);
    for (int k = 0; k < 6; k++)
    begin
      run(rsv[k]);
      rd(fcs_pkg::OFS_CMD, {24'h0, rsv[k]});
    end
    rd(fcs_pkg::OFS_ADR, 32'h3, 32'h3f);
    rd(fcs_pkg::OFS_DAT, {16'h0, m[3]});
    for (int k = 0; k < 4; k++)
    begin
      wr(fcs_pkg::OFS_TIM, k);
      rd(fcs_pkg::OFS_TIM, {24'h0, cost[k], 4'h0}, 32'hf0);
    end
    run(fcs_pkg::CMD_PING);
    cmp(irqs, 1, "ping interrupts");
    wr(fcs_pkg::OFS_ADR, 32'h9);
    run(fcs_pkg::CMD_ERASE);
    for (int j = 8; j < 16; j++) m[j] = 16'hffff;
    ck(8);
    ck(15);
    ck(16);
    wr(fcs_pkg::OFS_ADR, 32'd20);
    m[20] = 16'h1357;
    wr(fcs_pkg::OFS_DAT, {16'h0, m[20]});
    run(fcs_pkg::CMD_ERWR);
    for (int j = 16; j < 24; j++) if (j != 20) m[j] = 16'hffff;
    ck(20);
    ck(17);
    run(fcs_pkg::CMD_MASS);
    ck(0);
    wr(fcs_pkg::OFS_KEY, fcs_pkg::MASS_KEY);
    run(fcs_pkg::CMD_MASS);
    rd(fcs_pkg::OFS_CMD, 32'h7);
    for (int j = 0; j < 48; j++) m[j] = 16'hffff;
    ck(0);
    ck(47);
    ck(48);
    ck(63);
    wr(fcs_pkg::OFS_PRO, 32'h1);
    run(fcs_pkg::CMD_PROT);
    rd(fcs_pkg::OFS_PRO, 32'h1);
    wr(fcs_pkg::OFS_PRO, 32'h3);
    run(fcs_pkg::CMD_PROT);
    rd(fcs_pkg::OFS_PRO, 32'h1);
    wr(fcs_pkg::OFS_ADR, 32'h1);
    wr(fcs_pkg::OFS_DAT, 32'h2468);
    run(fcs_pkg::CMD_WRITE);
    rd(fcs_pkg::OFS_STA, 32'h8, 32'h8);
    ck(1);
    wr(fcs_pkg::OFS_KEY, fcs_pkg::PROT_KEY);
    wf(1, 16'h2468);
    ck(1);
    finish_test();
  end
endmodule : tb_fcs_top
